// file: verilog/error_status_bank.sv
// Sticky error status bank: throttle bins, general inputs, fans, host zones.
// Assumes a register port from the serial management engine on clk, and
// limit, mask and sleep-state values from neighbouring register logic.
//
// How it works
// - Throttle event bit sets when a window shows any nonzero throttling.
// - Exactly one bin bit among 1..5 sets per window below full throttle, by throttle fraction.
// - Full-throttle bit sets when throttle held the whole window.
// - Limit error bit sets when measured throttling exceeds the user limit.
// - Only throttle limit error of that register feeds board summary.
// - General input error bit sets while its pin is low and unmasked.
// - Fan error bit sets when tach count exceeds its limit.
// - Host summary asserts while any host error status bit is set.
// - Fixed throttle bins never feed the host summary.
// - Status bits stay set after the condition goes until cleared.
// - Clearing has no effect while the condition is still present.
// - Writing one clears a bit; writing zero leaves it unchanged.
// - Reported sleep state suppresses the events masked for it.
// - Optional sleep masking applies only when the mask selects it.
// - Zone 1 and 2 errors set on limit exit; optionally maskable in S3 and S45.
// - Zone 3 and 4 errors set on limit exit; never sleep masked.
// - Regulator hot inputs set bits 4 and 5; masked in S3 and S45.
`timescale 1ns/1ns
`include "error_status_cfg.svh"
module error_status_bank #(
    parameter int TACH_WIDTH = 16,
    parameter int WINDOW_LOG2 = `THROTTLE_WINDOW_LOG2,
    parameter int SAMPLE_CYCLES = `THROTTLE_SAMPLE_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic cpu2ThrottleInput_n,
    input wire logic [6:0] throttleLimitPercent,
    input wire logic [7:0] generalPurposePin,
    input wire logic [7:0] generalInputErrorMask,
    input wire logic [4*TACH_WIDTH-1:0] fanTachCount,
    input wire logic [4*TACH_WIDTH-1:0] fanTachLimit,
    input wire logic [3:0] zoneOutOfLimit,
    input wire logic regulatorOneHotInput_n,
    input wire logic regulatorTwoHotInput_n,
    input wire error_status_pkg::sleep_state_type sleepState,
    input wire logic [31:0] sleepOptMaskS1,
    input wire logic [31:0] sleepOptMaskS3,
    input wire logic [31:0] sleepOptMaskS45,
    output logic boardMgmtErrorSummary,
    output logic hostErrorSummary
);
    import error_status_pkg::*;

    localparam int CNT_W = WINDOW_LOG2 + 1;
    localparam int PROD_W = CNT_W + 7;
    localparam int SAMPLE_W = $clog2(SAMPLE_CYCLES + 1);

    // Pin synchronisers: stage one feeds stage two only
    logic [10:0] pinMeta_reg;
    logic [10:0] pinSync_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta_reg <= 11'h7FF;
            pinSync_reg <= 11'h7FF;
        end else begin
            pinMeta_reg <= {regulatorTwoHotInput_n, regulatorOneHotInput_n,
                            cpu2ThrottleInput_n, generalPurposePin};
            pinSync_reg <= pinMeta_reg;
        end
    end

    wire [7:0] gpiLow = ~pinSync_reg[7:0];
    wire throttleActive = ~pinSync_reg[8];
    wire regOneHot = ~pinSync_reg[9];
    wire regTwoHot = ~pinSync_reg[10];

    // Sample enable divider
    logic [SAMPLE_W-1:0] sampleCnt_reg;
    logic sampleEn_reg;
    wire sampleWrap = (sampleCnt_reg == SAMPLE_W'(SAMPLE_CYCLES - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sampleCnt_reg <= '0;
            sampleEn_reg <= 1'b0;
        end else begin
            sampleCnt_reg <= sampleWrap ? '0 : sampleCnt_reg + 1'b1;
            sampleEn_reg <= sampleWrap;
        end
    end

    // Throttle duty measurement over 2**WINDOW_LOG2 samples
    logic [WINDOW_LOG2-1:0] winCnt_reg;
    logic [CNT_W-1:0] hotCnt_reg;
    logic [CNT_W-1:0] result_reg;
    logic resultValid_reg;
    wire winLast = (winCnt_reg == {WINDOW_LOG2{1'b1}});
    wire [CNT_W-1:0] hotCntNext = hotCnt_reg + CNT_W'(throttleActive);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            winCnt_reg <= '0;
            hotCnt_reg <= '0;
            result_reg <= '0;
            resultValid_reg <= 1'b0;
        end else begin
            resultValid_reg <= sampleEn_reg && winLast;
            if (sampleEn_reg) begin
                winCnt_reg <= winCnt_reg + 1'b1;
                hotCnt_reg <= winLast ? '0 : hotCntNext;
                if (winLast) begin
                    result_reg <= hotCntNext;
                end
            end
        end
    end

    // Classification of a finished window
    wire fullThrottle = result_reg[CNT_W-1];
    wire [2:0] eighths = result_reg[WINDOW_LOG2-1:WINDOW_LOG2-3];
    wire [PROD_W-1:0] measuredScaled =
        PROD_W'(result_reg) * PROD_W'(`PERCENT_FULL_SCALE);
    wire [PROD_W-1:0] limitScaled =
        PROD_W'(throttleLimitPercent) << WINDOW_LOG2;
    logic [7:0] throttleEvents;

    always_comb begin
        throttleEvents = 8'h00;
        throttleEvents[`THROTTLE_EVENT_BIT] = |result_reg;
        throttleEvents[`FULL_THROTTLE_BIT] = fullThrottle;
        throttleEvents[`CPU2_THROTTLE_LIMIT_ERROR_BIT] =
            measuredScaled > limitScaled;
        if (!fullThrottle) begin
            case (eighths)
                3'h0: throttleEvents[`THROTTLE_BIN_0_TO_12_BIT] = 1'b1;
                3'h1: throttleEvents[`THROTTLE_BIN_12_TO_25_BIT] = 1'b1;
                3'h2, 3'h3: throttleEvents[`THROTTLE_BIN_25_TO_50_BIT] = 1'b1;
                3'h4, 3'h5: throttleEvents[`THROTTLE_BIN_50_TO_75_BIT] = 1'b1;
                default: throttleEvents[`THROTTLE_BIN_75_TO_100_BIT] = 1'b1;
            endcase
        end
        if (!resultValid_reg) begin
            throttleEvents = 8'h00;
        end
    end

    // Fan tach comparisons
    logic [3:0] fanOver;
    genvar f;
    generate
        for (f = 0; f < 4; f = f + 1) begin : gFan
            assign fanOver[f] =
                fanTachCount[f*TACH_WIDTH +: TACH_WIDTH] >
                fanTachLimit[f*TACH_WIDTH +: TACH_WIDTH];
        end
    endgenerate

    // Raw conditions over {reg48, reg47, reg46, reg45}
    wire [7:0] gpiCond = gpiLow & ~generalInputErrorMask;
    wire [7:0] fanCond = {4'h0, fanOver};
    wire [7:0] hostCond = {2'b00, regTwoHot, regOneHot,
                           zoneOutOfLimit};
    wire [31:0] rawCond = {hostCond, fanCond, gpiCond, throttleEvents};

    // Sleep masking: fixed part always, optional part by mask select
    logic [31:0] sleepMask;

    always_comb begin
        case (sleepState)
            SLEEP_S1: sleepMask = `FIXED_MASK_S1 |
                (`OPTIONAL_MASK_S1 & sleepOptMaskS1);
            SLEEP_S3: sleepMask = `FIXED_MASK_S3 |
                (`OPTIONAL_MASK_S3 & sleepOptMaskS3);
            SLEEP_S45: sleepMask = `FIXED_MASK_S45 |
                (`OPTIONAL_MASK_S45 & sleepOptMaskS45);
            default: sleepMask = 32'h0000_0000;
        endcase
    end

    wire [31:0] setCond = rawCond & ~sleepMask;

    // Write-one-to-clear strobes
    wire wr45 = regWrite && (regAddr == `CPU2_THROTTLE_ERROR_STATUS_ADDR);
    wire wr46 = regWrite && (regAddr == `GENERAL_INPUT_ERROR_STATUS_ADDR);
    wire wr47 = regWrite && (regAddr == `FAN_SPEED_ERROR_STATUS_ADDR);
    wire wr48 = regWrite &&
        (regAddr == `HOST_ZONE_REGULATOR_ERROR_STATUS_ADDR);
    wire [7:0] clr45 = wr45 ? regWrData : 8'h00;
    wire [7:0] clr46 = wr46 ? regWrData : 8'h00;
    wire [7:0] clr47 = wr47 ? regWrData : 8'h00;
    wire [7:0] clr48 = wr48 ? regWrData : 8'h00;

    status_byte_type cpu2ThrottleStatus;
    status_byte_type generalInputStatus;
    status_byte_type fanSpeedStatus;
    status_byte_type hostZoneStatus;

    // Sticky bits: held until cleared, set beats clear
    sticky_status_byte #(
        .IMPL_MASK(`CPU2_THROTTLE_IMPL_MASK)
    ) uThrottle (
        .clk(clk),
        .reset_n(reset_n),
        .setBits(setCond[7:0]),
        .clearBits(clr45),
        .value(cpu2ThrottleStatus)
    );

    sticky_status_byte #(
        .IMPL_MASK(`GENERAL_INPUT_IMPL_MASK)
    ) uGeneralInput (
        .clk(clk),
        .reset_n(reset_n),
        .setBits(setCond[15:8]),
        .clearBits(clr46),
        .value(generalInputStatus)
    );

    sticky_status_byte #(
        .IMPL_MASK(`FAN_SPEED_IMPL_MASK)
    ) uFanSpeed (
        .clk(clk),
        .reset_n(reset_n),
        .setBits(setCond[23:16]),
        .clearBits(clr47),
        .value(fanSpeedStatus)
    );

    sticky_status_byte #(
        .IMPL_MASK(`HOST_ZONE_IMPL_MASK)
    ) uHostZone (
        .clk(clk),
        .reset_n(reset_n),
        .setBits(setCond[31:24]),
        .clearBits(clr48),
        .value(hostZoneStatus)
    );

    // Read mux; unmapped offsets read zero
    logic [7:0] rdSelect;

    always_comb begin
        case (regAddr)
            `CPU2_THROTTLE_ERROR_STATUS_ADDR: rdSelect = cpu2ThrottleStatus;
            `GENERAL_INPUT_ERROR_STATUS_ADDR: rdSelect = generalInputStatus;
            `FAN_SPEED_ERROR_STATUS_ADDR: rdSelect = fanSpeedStatus;
            `HOST_ZONE_REGULATOR_ERROR_STATUS_ADDR: rdSelect = hostZoneStatus;
            default: rdSelect = 8'h00;
        endcase
    end

    // Summaries; bins of the throttle register feed neither
    wire boardSummaryNext =
        cpu2ThrottleStatus[`CPU2_THROTTLE_LIMIT_ERROR_BIT] |
        (|generalInputStatus) | (|fanSpeedStatus);
    wire hostSummaryNext = |hostZoneStatus;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 8'h00;
            boardMgmtErrorSummary <= 1'b0;
            hostErrorSummary <= 1'b0;
        end else begin
            regRdData <= rdSelect;
            boardMgmtErrorSummary <= boardSummaryNext;
            hostErrorSummary <= hostSummaryNext;
        end
    end
endmodule

// file: verilog/error_status_cfg.svh
// Offsets, field positions, reset values and timing for the error status bank.
// Assumes it is included by bare name from the package and the modules.
`ifndef ERROR_STATUS_CFG_SVH
`define ERROR_STATUS_CFG_SVH

// Register offsets
`define CPU2_THROTTLE_ERROR_STATUS_ADDR 8'h45
`define GENERAL_INPUT_ERROR_STATUS_ADDR 8'h46
`define FAN_SPEED_ERROR_STATUS_ADDR 8'h47
`define HOST_ZONE_REGULATOR_ERROR_STATUS_ADDR 8'h48

// Reset value shared by all four registers
`define STATUS_RESET_VALUE 8'h00

// Implemented bits; reserved bits read zero
`define CPU2_THROTTLE_IMPL_MASK 8'hFF
`define GENERAL_INPUT_IMPL_MASK 8'hFF
`define FAN_SPEED_IMPL_MASK 8'h0F
`define HOST_ZONE_IMPL_MASK 8'h3F

// Throttle register fields
`define THROTTLE_EVENT_BIT 0
`define THROTTLE_BIN_0_TO_12_BIT 1
`define THROTTLE_BIN_12_TO_25_BIT 2
`define THROTTLE_BIN_25_TO_50_BIT 3
`define THROTTLE_BIN_50_TO_75_BIT 4
`define THROTTLE_BIN_75_TO_100_BIT 5
`define FULL_THROTTLE_BIT 6
`define CPU2_THROTTLE_LIMIT_ERROR_BIT 7

// Host zone register fields
`define REGULATOR_ONE_HOT_ERROR_BIT 4
`define REGULATOR_TWO_HOT_ERROR_BIT 5

// Sleep masks over {reg48, reg47, reg46, reg45}; 1 means masked
`define FIXED_MASK_S1 32'h0000_0000
`define FIXED_MASK_S3 32'h3000_00FF
`define FIXED_MASK_S45 32'h300F_00FF
`define OPTIONAL_MASK_S1 32'h000F_FF00
`define OPTIONAL_MASK_S3 32'h030F_FF00
`define OPTIONAL_MASK_S45 32'h0300_FF00

// Throttle sampling
`define CLOCK_PERIOD_NS 8
`define THROTTLE_SAMPLE_NS 1000
`define THROTTLE_SAMPLE_CYCLES (`THROTTLE_SAMPLE_NS / `CLOCK_PERIOD_NS)
`define THROTTLE_WINDOW_LOG2 8
`define PERCENT_FULL_SCALE 100

`endif

// file: verilog/error_status_pkg.sv
// Types for the error status bank.
// Assumes error_status_cfg.svh is on the include path.
package error_status_pkg;
    `include "error_status_cfg.svh"

    typedef enum logic [1:0] {
        SLEEP_S0,
        SLEEP_S1,
        SLEEP_S3,
        SLEEP_S45
    } sleep_state_type;

    typedef logic [7:0] status_byte_type;
endpackage

// file: verilog/sticky_status_byte.sv
// One write-one-to-clear sticky status register.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ns
`include "error_status_cfg.svh"
module sticky_status_byte #(
    parameter logic [7:0] IMPL_MASK = 8'hFF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] setBits,
    input wire logic [7:0] clearBits,
    output logic [7:0] value
);
    import error_status_pkg::*;

    logic [7:0] value_reg;
    logic [7:0] value_next;

    // Set wins over a clear in the same cycle
    assign value_next = ((value_reg & ~clearBits) | setBits) & IMPL_MASK;
    assign value = value_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            value_reg <= `STATUS_RESET_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end
endmodule

// file: dv/error_status_bank_properties.sv
// Port assertions for the error status bank.
// Assumes a bind from the bench onto the bank.
`timescale 1ns/1ns
module error_status_bank_properties (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic [3:0] zoneOutOfLimit,
    input wire logic regulatorOneHotInput_n,
    input wire error_status_pkg::sleep_state_type sleepState,
    input wire logic boardMgmtErrorSummary,
    input wire logic hostErrorSummary
);
    import error_status_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_res47;
        $past(regAddr) == 8'h47 |-> regRdData[7:4] == 4'h0; endproperty
    a_res47: assert property (p_res47) else $error("fan spare bits");
    property p_res48;
        $past(regAddr) == 8'h48 |-> regRdData[7:6] == 2'h0; endproperty
    a_res48: assert property (p_res48) else $error("host spare bits");
    property p_unmap;
        !($past(regAddr) inside {[8'h45:8'h48]}) |-> regRdData == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_host;
        $past(regAddr) == 8'h48 |-> hostErrorSummary == (|regRdData);
    endproperty
    a_host: assert property (p_host) else $error("host summary");
    property p_board;
        $past(regAddr) == 8'h45 && regRdData[7] |-> boardMgmtErrorSummary;
    endproperty
    a_board: assert property (p_board) else $error("board summary");
    property p_zone3;
        zoneOutOfLimit[2] [*3] ##1 regAddr == 8'h48 && !regWrite
            |=> regRdData[2]; endproperty
    a_zone3: assert property (p_zone3) else $error("zone three");
    property p_vrm;
        (!regulatorOneHotInput_n && sleepState == SLEEP_S0) [*5]
            ##1 regAddr == 8'h48 && !regWrite |=> regRdData[4]; endproperty
    a_vrm: assert property (p_vrm) else $error("regulator one");
    property p_sticky;
        regAddr == 8'h46 && !regWrite ##1 regAddr == 8'h46 && !regWrite
            |=> ($past(regRdData) & ~regRdData) == 8'h00; endproperty
    a_sticky: assert property (p_sticky) else $error("bit fell");
    property p_clr;
        !zoneOutOfLimit[3] ##1 regWrite && regAddr == 8'h48 && regWrData[3]
            && !zoneOutOfLimit[3] ##1 regAddr == 8'h48 && !zoneOutOfLimit[3]
            |=> !regRdData[3]; endproperty
    a_clr: assert property (p_clr) else $error("clear lost");
    c_wr48: cover property (regWrite && regAddr == 8'h48);
    c_host: cover property ($rose(hostErrorSummary));
    c_board: cover property ($rose(boardMgmtErrorSummary));
endmodule

// file: dv/host_model.sv
// Host software model: register cycles and the reported sleep state.
// Assumes callers enter each task once a clock edge has settled.
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    output error_status_pkg::sleep_state_type sleepState
);
    import error_status_pkg::*;
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regWrData = 8'h00;
        sleepState = SLEEP_S0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1 regAddr = a;
        regWrite = 1'b1;
        regWrData = v;
        @(posedge clk);
        #1 regWrite = 1'b0;
        regWrData = ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1 regAddr = a;
        @(posedge clk);
        #1 v = regRdData;
    endtask
endmodule

// file: dv/error_status_bank_bench.sv
// Bench for the error status bank: pins, host model, reference model.
// Assumes package, design, host model and checker compile first.
`timescale 1ns/1ns
`define CHK(g, x) begin cmpCount++; if ((g) !== (x)) begin mismatches++; \
$display("CHECK FAILED %0t got %h exp %h", $time, g, x); end end
module error_status_bank_bench;
    import error_status_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cpu2ThrottleInput_n = 1'b1;
    logic regulatorOneHotInput_n = 1'b1;
    logic regulatorTwoHotInput_n = 1'b1;
    logic [6:0] throttleLimitPercent = 7'h28;
    logic [7:0] generalPurposePin = 8'hFF;
    logic [7:0] generalInputErrorMask = 8'h00;
    logic [63:0] fanTachCount = 64'h0;
    logic [63:0] fanTachLimit = 64'h0;
    logic [3:0] zoneOutOfLimit = 4'h0;
    logic [31:0] sleepOptMaskS1 = 32'h0;
    logic [31:0] sleepOptMaskS3 = 32'h0;
    logic [31:0] sleepOptMaskS45 = 32'h0;
    logic [7:0] regAddr, regWrData, regRdData, e, r, m;
    logic regWrite, boardMgmtErrorSummary, hostErrorSummary;
    sleep_state_type sleepState;
    int mismatches = 0, cmpCount = 0, cycles = 0, ph = 0, lowLen = 0;
    int seed = 32'h5EBC;
    int lens[6] = '{0, 2, 4, 8, 12, 16};
    host_model i_host (.clk, .regAddr, .regWrite, .regWrData, .regRdData,
        .sleepState);
    error_status_bank #(.TACH_WIDTH(16), .WINDOW_LOG2(3), .SAMPLE_CYCLES(2))
        i_dut (.clk, .reset_n, .regAddr, .regWrite, .regWrData, .regRdData,
        .cpu2ThrottleInput_n, .throttleLimitPercent, .generalPurposePin,
        .generalInputErrorMask, .fanTachCount, .fanTachLimit,
        .zoneOutOfLimit, .regulatorOneHotInput_n, .regulatorTwoHotInput_n,
        .sleepState, .sleepOptMaskS1, .sleepOptMaskS3,
        .sleepOptMaskS45, .boardMgmtErrorSummary, .hostErrorSummary);
    task automatic close_out;
        if (mismatches == 0 && cmpCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] got;
        i_host.rd(a, got);
        `CHK(got, x)
    endtask
    // Expected throttle byte for c throttled samples out of eight
    function automatic logic [7:0] thrExp(input int c);
        thrExp = {c * 100 > 8 * int'(throttleLimitPercent), c == 8,
            c >= 6 && c < 8, c >= 4 && c < 6, c >= 2 && c < 4, c == 1,
            c == 0, c > 0};
    endfunction
    always #4 clk = ~clk;
    // Throttle pattern: lowLen cycles asserted out of every 16
    always @(posedge clk) begin
        #1 ph = (ph + 1) % 16;
        cpu2ThrottleInput_n = !(ph < lowLen);
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            close_out;
        end
    end
    initial begin
        #29 reset_n = 1'b1;
        for (int a = 8'h44; a < 8'h4A; a++)
            if (a != 8'h45) chk(a[7:0], 8'h00);
        r = 8'($random(seed)) & 8'h7F;
        m = 8'($random(seed));
        generalPurposePin = r;
        generalInputErrorMask = m;
        repeat (4) @(posedge clk);
        #1 generalPurposePin = 8'hFF;
        e = ~r & ~m;
        chk(8'h46, e);
        `CHK(boardMgmtErrorSummary, |e)
        i_host.wr(8'h46, 8'hFF);
        chk(8'h46, 8'h00);
        for (int f = 0; f < 4; f++) begin
            fanTachCount[f*16 +: 16] = 16'($random(seed));
            fanTachLimit[f*16 +: 16] = 16'($random(seed));
        end
        fanTachLimit[15:0] = fanTachCount[15:0];
        for (int f = 0; f < 8; f++)
            e[f] = f < 4 && fanTachCount[f*16 +: 16] > fanTachLimit[f*16 +: 16];
        repeat (3) @(posedge clk);
        #1 fanTachCount = 64'h0;
        chk(8'h47, e);
        i_host.wr(8'h47, 8'hFF);
        chk(8'h47, 8'h00);
        i_host.sleepState = SLEEP_S3;
        sleepOptMaskS3 = 32'h0100_0000;
        zoneOutOfLimit = 4'hF;
        regulatorOneHotInput_n = 1'b0;
        regulatorTwoHotInput_n = 1'b0;
        repeat (6) @(posedge clk);
        chk(8'h48, 8'h0E);
        `CHK(hostErrorSummary, 1'b1)
        i_host.wr(8'h48, 8'hFF);
        chk(8'h48, 8'h0E);
        zoneOutOfLimit = 4'h0;
        i_host.sleepState = SLEEP_S0;
        repeat (6) @(posedge clk);
        chk(8'h48, 8'h3E);
        regulatorOneHotInput_n = 1'b1;
        regulatorTwoHotInput_n = 1'b1;
        repeat (4) @(posedge clk);
        i_host.wr(8'h48, 8'h0F);
        chk(8'h48, 8'h30);
        i_host.wr(8'h48, 8'hF0);
        chk(8'h48, 8'h00);
        `CHK(hostErrorSummary, 1'b0)
        // Deep sleep, then light sleep, with fixed and optional masks
        i_host.sleepState = SLEEP_S45;
        sleepOptMaskS45 = 32'h0200_0000;
        sleepOptMaskS1 = 32'h000F_0000;
        generalInputErrorMask = 8'h00;
        zoneOutOfLimit = 4'h3;
        regulatorOneHotInput_n = 1'b0;
        fanTachLimit[15:0] = 16'h0000;
        fanTachCount[15:0] = 16'h0001;
        generalPurposePin = 8'hFE;
        repeat (6) @(posedge clk);
        chk(8'h48, 8'h01);
        chk(8'h47, 8'h00);
        chk(8'h46, 8'h01);
        `CHK(boardMgmtErrorSummary, 1'b1)
        i_host.sleepState = SLEEP_S1;
        repeat (6) @(posedge clk);
        chk(8'h48, 8'h13);
        chk(8'h47, 8'h00);
        zoneOutOfLimit = 4'h0;
        regulatorOneHotInput_n = 1'b1;
        fanTachCount = 64'h0;
        generalPurposePin = 8'hFF;
        i_host.sleepState = SLEEP_S0;
        repeat (4) @(posedge clk);
        i_host.wr(8'h48, 8'hFF);
        i_host.wr(8'h47, 8'hFF);
        i_host.wr(8'h46, 8'hFF);
        chk(8'h48, 8'h00);
        for (int i = 0; i < 6; i++) begin
            lowLen = lens[i];
            repeat (48) @(posedge clk);
            i_host.wr(8'h45, 8'hFF);
            repeat (40) @(posedge clk);
            e = thrExp(lens[i] / 2);
            chk(8'h45, e);
            `CHK(boardMgmtErrorSummary, e[7])
            `CHK(hostErrorSummary, 1'b0)
        end
        close_out;
    end
endmodule
bind error_status_bank error_status_bank_properties i_chk (.clk, .reset_n,
    .regAddr, .regWrite, .regWrData, .regRdData, .zoneOutOfLimit,
    .regulatorOneHotInput_n, .sleepState, .boardMgmtErrorSummary,
    .hostErrorSummary);
